// ---- rtl/pmd_core.sv ----
`timescale 1ns/1ps
module pmd_core #(
    parameter logic [pmd_pkg::CNT_W-1:0] FILT_CYC  = pmd_pkg::FILT_CYC,
    parameter logic [pmd_pkg::CNT_W-1:0] OS_CYC    = pmd_pkg::OS_CYC,
    parameter logic [pmd_pkg::CNT_W-1:0] WIN_CYC   = pmd_pkg::WIN_CYC,
    parameter logic [pmd_pkg::CNT_W-1:0] DUR_CYC   = pmd_pkg::DUR_CYC,
    parameter bit                        UV_IGNORE = 1'b0
) (
    input  wire logic                core_clk,
    input  wire logic                srst,
    input  wire pmd_pkg::pmd_pins_s  pin_in,
    output logic                     alarm_output,
    output logic                     alarm_output_n,
    output logic                     alarm_pin_o,
    output logic                     alarm_pin_oe_n,
    output logic                     alarm_cpl_pin_o,
    output logic                     alarm_cpl_pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // input synchroniser
    logic [7:0]         meta_r;
    logic [7:0]         sync_r;
    logic [7:0]         meta_nxt;
    logic [7:0]         sync_nxt;
    pmd_pkg::pmd_pins_s pins;

    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    // two flops per input before any use
    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_r <= pmd_pkg::SYNC_RST;
            sync_r <= pmd_pkg::SYNC_RST;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pins = pmd_pkg::pmd_pins_s'(sync_r);

    ////////////////////////////////////////////////////////////////////////
    // mode decode: open checked before level
    pmd_pkg::pmd_mode_e mode;

    always_comb begin
        if (pins.mode_open) begin
            mode = pmd_pkg::concurrent_pulse_mode;
        end else if (pins.mode_lvl) begin
            mode = pmd_pkg::dual_pulse_mode;
        end else begin
            mode = pmd_pkg::single_pulse_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // persistence filters, one per polarity
    logic [pmd_pkg::CNT_W-1:0] fcnt_r   [2];
    logic [pmd_pkg::CNT_W-1:0] fcnt_nxt [2];
    logic [1:0]                fpulse_r;
    logic [1:0]                fpulse_nxt;
    logic [1:0]                comp;

    assign comp = {pins.comp_neg, pins.comp_pos};

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            fcnt_nxt[i]   = pmd_pkg::CNT_RST;
            fpulse_nxt[i] = 1'b0;
            if (comp[i]) begin
                // saturate so one episode gives one pulse
                fcnt_nxt[i] = (fcnt_r[i] == FILT_CYC) ? fcnt_r[i]
                            : fcnt_r[i] + 32'h0000_0001;
                fpulse_nxt[i] =
                    (fcnt_r[i] == FILT_CYC - 32'h0000_0001);
            end
        end
    end

    // register filter state
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fcnt_r[0] <= pmd_pkg::CNT_RST;
            fcnt_r[1] <= pmd_pkg::CNT_RST;
            fpulse_r  <= 2'h0;
        end else begin
            fcnt_r[0] <= fcnt_nxt[0];
            fcnt_r[1] <= fcnt_nxt[1];
            fpulse_r  <= fpulse_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one-shots, window and duration timers
    logic [1:0] os_act;
    logic       win_act;
    logic       dur_act;
    logic       any_pulse;
    logic       both_pulse;
    logic       both_os;
    logic       win_start;
    logic       qual;
    logic       both_d_r;
    logic       both_d_nxt;

    for (genvar g = 0; g < 2; g++) begin : g_os
        pmd_rtimer u_os (
            .core_clk (core_clk),
            .srst     (srst),
            .start    (fpulse_r[g]),
            .clear    (1'b0),
            .load     (OS_CYC),
            .active   (os_act[g])
        );
    end

    assign any_pulse  = |fpulse_r;
    assign both_pulse = &fpulse_r;
    assign both_os    = &os_act;

    // qualification per mode
    always_comb begin
        qual      = 1'b0;
        win_start = 1'b0;
        unique case (mode)
            pmd_pkg::single_pulse_mode: begin
                qual = any_pulse;
            end
            pmd_pkg::concurrent_pulse_mode: begin
                // overlap begins, or new detection during overlap
                qual = both_os && (!both_d_r || any_pulse);
            end
            pmd_pkg::dual_pulse_mode: begin
                qual      = (any_pulse && win_act) || both_pulse;
                win_start = any_pulse && !qual;
            end
        endcase
        both_d_nxt = both_os;
    end

    pmd_rtimer u_win (
        .core_clk (core_clk),
        .srst     (srst),
        .start    (win_start),
        .clear    (qual),
        .load     (WIN_CYC),
        .active   (win_act)
    );

    pmd_rtimer u_dur (
        .core_clk (core_clk),
        .srst     (srst),
        .start    (qual),
        .clear    (1'b0),
        .load     (DUR_CYC),
        .active   (dur_act)
    );

    ////////////////////////////////////////////////////////////////////////
    // alarm and pin drive
    logic uv_term;
    logic alarm_r;
    logic alarm_nxt;

    // undervoltage only with select driven low, not open
    assign uv_term = !UV_IGNORE && !pins.udv_sel_lvl
                     && !pins.udv_sel_open && pins.uv_low;

    always_comb begin
        alarm_nxt = (dur_act || uv_term) && !pins.enable_n;
    end

    // registered outputs; true pin sinks on alarm
    always_ff @(posedge core_clk) begin
        if (srst) begin
            alarm_r            <= 1'b0;
            both_d_r           <= 1'b0;
            alarm_output       <= 1'b0;
            alarm_output_n     <= 1'b1;
            alarm_pin_o        <= 1'b0;
            alarm_pin_oe_n     <= 1'b1;
            alarm_cpl_pin_o    <= 1'b0;
            alarm_cpl_pin_oe_n <= 1'b0;
        end else begin
            alarm_r            <= alarm_nxt;
            both_d_r           <= both_d_nxt;
            alarm_output       <= alarm_nxt;
            alarm_output_n     <= !alarm_nxt;
            alarm_pin_o        <= 1'b0;
            alarm_pin_oe_n     <= !alarm_nxt;
            alarm_cpl_pin_o    <= 1'b0;
            alarm_cpl_pin_oe_n <= alarm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    filt_pulse_a: assert property (
        @(posedge core_clk) disable iff (srst)
        fpulse_r[0] |-> fcnt_r[0] == FILT_CYC && $past(comp[0]))
        else $error("filter pulse without full persistence");

    os_start_a: assert property (
        @(posedge core_clk) disable iff (srst)
        fpulse_r[1] |=> os_act[1])
        else $error("one-shot not started by detection");

    single_alarm_a: assert property (
        @(posedge core_clk) disable iff (srst)
        (mode == pmd_pkg::single_pulse_mode && any_pulse
         && !pins.enable_n ##1 !pins.enable_n) |=> alarm_r)
        else $error("single mode detection did not alarm");

    conc_both_a: assert property (
        @(posedge core_clk) disable iff (srst)
        mode == pmd_pkg::concurrent_pulse_mode && qual |-> both_os)
        else $error("concurrent qualify without overlap");

    dual_win_a: assert property (
        @(posedge core_clk) disable iff (srst)
        mode == pmd_pkg::dual_pulse_mode && any_pulse && !win_act
        && !both_pulse |=> win_act)
        else $error("lone dual detection did not open window");

    dur_run_a: assert property (
        @(posedge core_clk) disable iff (srst)
        qual |=> dur_act)
        else $error("duration timer not started");

    dormant_hold_a: assert property (
        @(posedge core_clk) disable iff (srst)
        pins.enable_n |=> !alarm_output && alarm_pin_oe_n)
        else $error("alarm active while disabled");

    quiet_idle_a: assert property (
        @(posedge core_clk) disable iff (srst)
        !dur_act && !uv_term |=> !alarm_r)
        else $error("alarm without cause");

    cpl_pair_a: assert property (
        @(posedge core_clk) disable iff (srst)
        alarm_output != alarm_output_n
        && alarm_pin_oe_n == alarm_cpl_pin_oe_n ^ 1'b1)
        else $error("outputs not complementary");

endmodule

// ---- rtl/pmd_pkg.sv ----
package pmd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_KHZ  = 250000;
    localparam int unsigned FILT_MS  = 50;
    localparam int unsigned OS_MS    = 1000;
    localparam int unsigned WIN_MS   = 2500;
    localparam int unsigned DUR_MS   = 4000;
    localparam int          CNT_W    = 32;

    // cycle counts derived from the times above
    localparam logic [CNT_W-1:0] FILT_CYC =
        CNT_W'(64'(FILT_MS) * 64'(CLK_KHZ));
    localparam logic [CNT_W-1:0] OS_CYC   =
        CNT_W'(64'(OS_MS) * 64'(CLK_KHZ));
    localparam logic [CNT_W-1:0] WIN_CYC  =
        CNT_W'(64'(WIN_MS) * 64'(CLK_KHZ));
    localparam logic [CNT_W-1:0] DUR_CYC  =
        CNT_W'(64'(DUR_MS) * 64'(CLK_KHZ));

    // reset values
    localparam logic [CNT_W-1:0] CNT_RST  = 32'h0000_0000;
    localparam logic [7:0]       SYNC_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        single_pulse_mode,
        concurrent_pulse_mode,
        dual_pulse_mode
    } pmd_mode_e;

    // asynchronous pin levels from the analog front end and straps
    typedef struct packed {
        logic comp_pos;
        logic comp_neg;
        logic mode_lvl;
        logic mode_open;
        logic enable_n;
        logic udv_sel_lvl;
        logic udv_sel_open;
        logic uv_low;
    } pmd_pins_s;

endpackage

// ---- rtl/pmd_rtimer.sv ----
`timescale 1ns/1ps
module pmd_rtimer (
    input  wire logic                         core_clk,
    input  wire logic                         srst,
    input  wire logic                         start,
    input  wire logic                         clear,
    input  wire logic [pmd_pkg::CNT_W-1:0]    load,
    output logic                              active
);

    logic [pmd_pkg::CNT_W-1:0] cnt_r;
    logic [pmd_pkg::CNT_W-1:0] cnt_nxt;

    ////////////////////////////////////////////////////////////////////////
    // retriggerable countdown: start reloads, clear wins
    always_comb begin
        cnt_nxt = cnt_r;
        if (clear) begin
            cnt_nxt = pmd_pkg::CNT_RST;
        end else if (start) begin
            cnt_nxt = load;
        end else if (cnt_r != pmd_pkg::CNT_RST) begin
            cnt_nxt = cnt_r - 32'h0000_0001;
        end
    end

    // register the count
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_r <= pmd_pkg::CNT_RST;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign active = (cnt_r != pmd_pkg::CNT_RST);

    // a restart reloads the full width
    reload_full_a: assert property (
        @(posedge core_clk) disable iff (srst)
        start && !clear |=> cnt_r == $past(load))
        else $error("timer did not reload on start");

    // clear always empties the timer
    clear_empty_a: assert property (
        @(posedge core_clk) disable iff (srst)
        clear |=> !active)
        else $error("timer still active after clear");

endmodule

// ---- tb/pmd_fe_model.sv ----
`timescale 1ns/1ps
// comparator front end: holds a detection line high for len cycles
module pmd_fe_model (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       fire_pos,
    input  wire logic       fire_neg,
    input  wire logic [7:0] len,
    output logic            comp_pos,
    output logic            comp_neg
);
    logic [7:0] pos_r;
    logic [7:0] neg_r;
    ////////////////////////////////////////////////////////////////////////
    // one hold counter per polarity, lines driven low when quiet
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pos_r <= 8'h00;
            neg_r <= 8'h00;
        end else begin
            pos_r <= fire_pos ? len : pos_r - 8'(pos_r != 8'h00);
            neg_r <= fire_neg ? len : neg_r - 8'(neg_r != 8'h00);
        end
    end
    assign comp_pos = (pos_r != 8'h00);
    assign comp_neg = (neg_r != 8'h00);
endmodule

// ---- tb/test_pir_motion_detect_logic.sv ----
`timescale 1ns/1ps
module test_pir_motion_detect_logic;
    localparam logic [5:0] ALM  = 6'h21;
    localparam logic [5:0] IDLE = 6'h14;
    logic               core_clk  = 1'h0;
    logic               srst      = 1'h1;
    logic               fire_pos  = 1'h0;
    logic               fire_neg  = 1'h0;
    logic [7:0]         len       = 8'h00;
    logic               mode_lvl  = 1'h0;
    logic               mode_open = 1'h0;
    logic               enable_n  = 1'h0;
    logic               sel_lvl   = 1'h0;
    logic               sel_open  = 1'h0;
    logic               uv_low    = 1'h0;
    logic               smp       = 1'h0;
    logic               cp;
    logic               cn;
    logic [5:0]         obs;
    logic [5:0]         exp_q[$];
    pmd_pkg::pmd_pins_s pins;
    int                 miscompares = 0;
    int                 checked     = 0;
    int                 cycles      = 0;
    int                 seed        = 32'hbccf;
    ////////////////////////////////////////////////////////////////////////
    // clock, pins and instances
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always_comb begin
        pins = {cp, cn, mode_lvl, mode_open, enable_n, sel_lvl, sel_open,
                uv_low};
    end
    pmd_fe_model u_fe (.core_clk(core_clk), .srst(srst),
        .fire_pos(fire_pos), .fire_neg(fire_neg), .len(len),
        .comp_pos(cp), .comp_neg(cn));
    pmd_core #(.FILT_CYC(32'h8), .OS_CYC(32'h28), .WIN_CYC(32'h3C),
        .DUR_CYC(32'h1E)) u_dut (.core_clk(core_clk), .srst(srst),
        .pin_in(pins), .alarm_output(obs[5]), .alarm_output_n(obs[4]),
        .alarm_pin_o(obs[3]), .alarm_pin_oe_n(obs[2]),
        .alarm_cpl_pin_o(obs[1]), .alarm_cpl_pin_oe_n(obs[0]));
    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic stop_test();
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one detection burst, then settle for nineteen cycles
    task automatic hit(input logic p, input logic n, input logic lng);
        fire_pos <= p;
        fire_neg <= n;
        len      <= 8'((lng ? 10 : 1) + $unsigned($random(seed)) % 6);
        @(posedge core_clk);
        fire_pos <= 1'h0;
        fire_neg <= 1'h0;
        step(19);
    endtask
    task automatic expect_out(input logic [5:0] e);
        exp_q.push_back(e);
        smp <= 1'h1;
        @(posedge core_clk);
        smp <= 1'h0;
    endtask
    task automatic check_out(input logic [5:0] e);
        checked++;
        if (obs !== e) begin
            miscompares++;
            $display("FAIL alarm outputs expected %h seen %h", e, obs);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // monitor and hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (smp === 1'h1) begin
            check_out(exp_q.pop_front());
        end
        if (cycles == 4000) begin
            miscompares++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        step(2);
        srst <= 1'h0;
        step(1);
        expect_out(IDLE);
        // single mode
        hit(1'h1, 1'h0, 1'h0);
        expect_out(IDLE);
        hit(1'h1, 1'h0, 1'h1);
        expect_out(ALM);
        // second detection restarts the duration timer
        hit(1'h0, 1'h1, 1'h1);
        step(10);
        expect_out(ALM);
        // mid-run reset clears timers and alarm
        srst <= 1'h1;
        step(2);
        srst <= 1'h0;
        step(1);
        expect_out(IDLE);
        step(60);
        expect_out(IDLE);
        hit(1'h0, 1'h1, 1'h1);
        expect_out(ALM);
        step(60);
        // dormant while enable is high
        enable_n <= 1'h1;
        hit(1'h1, 1'h0, 1'h1);
        expect_out(IDLE);
        step(60);
        enable_n <= 1'h0;
        step(4);
        expect_out(IDLE);
        // undervoltage
        uv_low <= 1'h1;
        step(6);
        expect_out(ALM);
        uv_low <= 1'h0;
        step(6);
        expect_out(IDLE);
        sel_open <= 1'h1;
        uv_low   <= 1'h1;
        step(6);
        expect_out(IDLE);
        sel_open <= 1'h0;
        sel_lvl  <= 1'h1;
        step(6);
        expect_out(IDLE);
        uv_low   <= 1'h0;
        sel_lvl  <= 1'h0;
        // concurrent mode
        mode_open <= 1'h1;
        step(4);
        hit(1'h1, 1'h0, 1'h1);
        expect_out(IDLE);
        hit(1'h0, 1'h1, 1'h1);
        expect_out(ALM);
        step(100);
        hit(1'h1, 1'h0, 1'h1);
        step(60);
        hit(1'h0, 1'h1, 1'h1);
        expect_out(IDLE);
        step(100);
        // dual mode
        mode_open <= 1'h0;
        mode_lvl  <= 1'h1;
        step(4);
        hit(1'h1, 1'h0, 1'h1);
        expect_out(IDLE);
        hit(1'h1, 1'h0, 1'h1);
        expect_out(ALM);
        step(100);
        hit(1'h0, 1'h1, 1'h1);
        step(80);
        hit(1'h0, 1'h1, 1'h1);
        expect_out(IDLE);
        step(4);
        stop_test();
    end
endmodule
